/* src/prioritized_interrupt_controller.v */
// Ten-source, four-level interrupt controller with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_defs.vh"
module prioritized_interrupt_controller (
  input wire hclk,
  input wire hresetn,
  input wire ce,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire ext_irq_pin_a_n,
  input wire ext_irq_pin_b_n,
  input wire tmr0_irq,
  input wire tmr1_irq,
  input wire tmr2_irq,
  input wire serial_irq,
  input wire spi_irq,
  input wire keyboard_irq,
  input wire counter_array_irq,
  input wire two_wire_irq,
  output reg irq_req,
  output reg [15:0] irq_vector,
  output reg [1:0] irq_level,
  input wire irq_ack,
  input wire irq_return
);
  localparam N = `NUM_SRC;

  function [15:0] vec_of;
    input [3:0] idx;
    begin
      case (idx)
        `SRC_PIN_A: vec_of = `VEC_PIN_A;
        `SRC_TMR0: vec_of = `VEC_TMR0;
        `SRC_PIN_B: vec_of = `VEC_PIN_B;
        `SRC_TMR1: vec_of = `VEC_TMR1;
        `SRC_SERIAL: vec_of = `VEC_SERIAL;
        `SRC_TMR2: vec_of = `VEC_TMR2;
        `SRC_CNT_ARRAY: vec_of = `VEC_CNT_ARRAY;
        `SRC_KEYBOARD: vec_of = `VEC_KEYBOARD;
        `SRC_SPI: vec_of = `VEC_SPI;
        `SRC_TWO_WIRE: vec_of = `VEC_TWO_WIRE;
        default: vec_of = `VEC_NONE;
      endcase
    end
  endfunction

  // Highest set in-service bit, plus whether any is set
  function [2:0] top_level;
    input [3:0] insv;
    begin
      if (insv[3])
        top_level = 3'b111;
      else if (insv[2])
        top_level = 3'b110;
      else if (insv[1])
        top_level = 3'b101;
      else if (insv[0])
        top_level = 3'b100;
      else
        top_level = 3'b000;
    end
  endfunction

  // Word offset of a byte address; sub-word bits ignored
  function [11:0] word_ofs;
    input [11:0] addr;
    begin
      word_ofs = {addr[11:2], 2'b00};
    end
  endfunction

  // Pins are asynchronous: two flops before use
  reg [1:0] pin_a_sync_q;
  reg [1:0] pin_b_sync_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_a_sync_q <= 2'h3;
      pin_b_sync_q <= 2'h3;
    end else if (ce) begin
      pin_a_sync_q <= {pin_a_sync_q[0], ext_irq_pin_a_n};
      pin_b_sync_q <= {pin_b_sync_q[0], ext_irq_pin_b_n};
    end
  end

  wire [N-1:0] raw_req;
  assign raw_req = {two_wire_irq, spi_irq, keyboard_irq, counter_array_irq,
                    tmr2_irq, serial_irq, tmr1_irq, ~pin_b_sync_q[1],
                    tmr0_irq, ~pin_a_sync_q[1]};

  reg [15:0] enable_q;
  reg [N-1:0] prio_low_q;
  reg [N-1:0] prio_high_q;
  reg [3:0] insv_q;
  reg [3:0] insv_d;

  wire [N-1:0] pend;
  assign pend = raw_req & enable_q[N-1:0]
              & {N{enable_q[`EN_GLOBAL_BIT]}};

  wire found;
  wire [3:0] win_idx;
  wire [1:0] win_lvl;
  level_arbiter #(.N(N)) u_arb (
    .req(pend),
    .prio_high(prio_high_q),
    .prio_low(prio_low_q),
    .found(found),
    .win_idx(win_idx),
    .win_lvl(win_lvl)
  );

  // In-service tracking: ack pushes the offered level, return pops top
  reg [2:0] top_cur;
  always @* begin
    insv_d = insv_q;
    top_cur = top_level(insv_q);
    if (irq_return && top_cur[2])
      insv_d[top_cur[1:0]] = 1'b0;
    if (irq_ack && irq_req)
      insv_d[irq_level] = 1'b1;
  end

  // Offer only when strictly above the running level; level 3 never beaten
  reg [2:0] top_nxt;
  reg offer;
  always @* begin
    top_nxt = top_level(insv_d);
    offer = found && (!top_nxt[2] || win_lvl > top_nxt[1:0]);
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      insv_q <= 4'h0;
      irq_req <= 1'b0;
      irq_vector <= `VEC_NONE;
      irq_level <= 2'h0;
    end else if (ce) begin
      insv_q <= insv_d;
      irq_req <= offer;
      irq_vector <= offer ? vec_of(win_idx) : `VEC_NONE;
      irq_level <= offer ? win_lvl : 2'h0;
    end
  end

  // AHB-Lite slave, zero wait states; stalls while frozen
  reg wr_pend_q;
  reg [11:0] wr_addr_q;
  wire take;
  assign take = hsel & htrans[1] & hready & ce;
  assign hreadyout = ce;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata <= 32'h00000000;
    end else if (ce) begin
      wr_pend_q <= take & hwrite;
      wr_addr_q <= haddr;
      if (take && !hwrite) begin
        case (word_ofs(haddr))
          `OFS_ENABLE: hrdata <= {16'h0000, enable_q};
          `OFS_PRIO_LOW: hrdata <= {22'h000000, prio_low_q};
          `OFS_PRIO_HIGH: hrdata <= {22'h000000, prio_high_q};
          `OFS_STATUS: hrdata <= {7'h00, irq_req, 4'h0, insv_q,
                                  6'h00, pend};
          `OFS_VECTOR: hrdata <= {14'h0000, irq_level, irq_vector};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_q <= `RST_ENABLE;
      prio_low_q <= `RST_PRIO;
      prio_high_q <= `RST_PRIO;
    end else if (ce && wr_pend_q) begin
      case (word_ofs(wr_addr_q))
        `OFS_ENABLE:
          enable_q <= {hwdata[`EN_GLOBAL_BIT], 5'h00, hwdata[N-1:0]};
        `OFS_PRIO_LOW: prio_low_q <= hwdata[N-1:0];
        `OFS_PRIO_HIGH: prio_high_q <= hwdata[N-1:0];
        default: enable_q <= enable_q;
      endcase
    end
  end
endmodule // prioritized_interrupt_controller
`default_nettype wire

/* src/irq_ctrl_defs.vh */
// Constants for the prioritized interrupt controller
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH

`define NUM_SRC 10
`define NUM_LVL 4

// Source index is also the polling position
`define SRC_PIN_A 4'h0
`define SRC_TMR0 4'h1
`define SRC_PIN_B 4'h2
`define SRC_TMR1 4'h3
`define SRC_SERIAL 4'h4
`define SRC_TMR2 4'h5
`define SRC_CNT_ARRAY 4'h6
`define SRC_KEYBOARD 4'h7
`define SRC_SPI 4'h8
`define SRC_TWO_WIRE 4'h9

`define VEC_PIN_A 16'h0003
`define VEC_TMR0 16'h000B
`define VEC_PIN_B 16'h0013
`define VEC_TMR1 16'h001B
`define VEC_SERIAL 16'h0023
`define VEC_TMR2 16'h002B
`define VEC_CNT_ARRAY 16'h0033
`define VEC_SPI 16'h0043
`define VEC_KEYBOARD 16'h004B
`define VEC_TWO_WIRE 16'h0053
`define VEC_NONE 16'h0000

// Register byte offsets
`define OFS_ENABLE 12'h000
`define OFS_PRIO_LOW 12'h004
`define OFS_PRIO_HIGH 12'h008
`define OFS_STATUS 12'h00C
`define OFS_VECTOR 12'h010

// Field positions
`define EN_GLOBAL_BIT 15
`define ST_PEND_LSB 0
`define ST_INSV_LSB 16
`define ST_REQ_BIT 24

`define RST_ENABLE 16'h0000
`define RST_PRIO 10'h000

`endif

/* src/level_arbiter.v */
// Picks the highest-level request, earliest polling position on a tie
`timescale 1ns/1ps
`default_nettype none
module level_arbiter #(
  parameter N = 10
) (
  input wire [N-1:0] req,
  input wire [N-1:0] prio_high,
  input wire [N-1:0] prio_low,
  output reg found,
  output reg [3:0] win_idx,
  output reg [1:0] win_lvl
);
  integer i;
  always @* begin
    found = 1'b0;
    win_idx = 4'h0;
    win_lvl = 2'h0;
    for (i = 0; i < N; i = i + 1) begin
      // Strictly greater keeps the earlier poll slot on equal level
      if (req[i] &&
          (!found || {prio_high[i], prio_low[i]} > win_lvl)) begin
        found = 1'b1;
        win_idx = i[3:0];
        win_lvl = {prio_high[i], prio_low[i]};
      end
    end
  end
endmodule // level_arbiter
`default_nettype wire

/* bench/prioritized_interrupt_controller_sva.sv */
// Port assertions for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic tmr0_irq,
  input wire logic spi_irq,
  input wire logic keyboard_irq,
  input wire logic counter_array_irq,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [1:0] irq_level
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Offer taken; a return right after would lower the in-service top
  sequence s_taken;
    ce && irq_req && irq_ack ##1 ce && !irq_return;
  endsequence
  a_idle_quiet: assert property (!irq_req |->
    irq_vector == 16'h0000 && irq_level == 2'h0) else $error("idle");
  a_vec_legal: assert property (irq_req |->
    irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0053) else $error("vec");
  a_tmr0_cause: assert property (irq_req && irq_vector == 16'h000B
    && $past(ce) |-> $past(tmr0_irq)) else $error("tmr0");
  a_spi_cause: assert property (irq_req && irq_vector == 16'h0043
    && $past(ce) |-> $past(spi_irq)) else $error("spi");
  a_kbd_cause: assert property (irq_req && irq_vector == 16'h004B
    && $past(ce) |-> $past(keyboard_irq)) else $error("kbd");
  a_cnt_cause: assert property (irq_req && irq_vector == 16'h0033
    && $past(ce) |-> $past(counter_array_irq)) else $error("cnt");
  a_preempt_up: assert property (s_taken |=> !irq_req ||
    irq_level > $past(irq_level, 2)) else $error("preempt");
  a_top_blocks: assert property (irq_level == 2'h3 ##0 s_taken
    |=> !irq_req) else $error("top");
endmodule // irq_chk
bind prioritized_interrupt_controller irq_chk u_chk (.*);
`default_nettype wire

/* bench/core_model.sv */
// Behavioural core taking the offered interrupts
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic go,
  input wire logic do_ret,
  input wire logic [1:0] wn,
  output logic irq_ack,
  output logic irq_return,
  output logic [15:0] got
);
  logic [1:0] cnt_q;
  // One pulse only, since irq_req lags the ack by a cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {irq_ack, irq_return, cnt_q, got} <= '0;
    end else begin
      irq_return <= do_ret;
      irq_ack <= go && irq_req && !irq_ack && cnt_q == wn;
      cnt_q <= (go && irq_req && !irq_ack) ? cnt_q + 2'h1 : 2'h0;
      if (irq_ack) got <= irq_vector;
    end
  end
endmodule // core_model
`default_nettype wire

/* bench/prioritized_interrupt_controller_tb.sv */
// Random self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module prioritized_interrupt_controller_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, do_ret = 0;
  logic hreadyout, hresp, irq_req, irq_ack, irq_return;
  logic [1:0] htrans = 0, wn = 0, irq_level, lv;
  logic [11:0] haddr = 0;
  logic [31:0] hwdata = 0, hrdata, d;
  logic [15:0] irq_vector, got, en, ev, sd = 16'h0007;
  logic [9:0] rq = 0, pl, ph, pe;
  logic [3:0] iv;
  logic [31:0] st;
  logic ce = 1'b1;
  int fail_count = 0, cmp_count = 0, cyc = 0, b, stk[$];
  wire ext_irq_pin_a_n = ~rq[0], tmr0_irq = rq[1], ext_irq_pin_b_n = ~rq[2];
  wire tmr1_irq = rq[3], serial_irq = rq[4], tmr2_irq = rq[5];
  wire counter_array_irq = rq[6], keyboard_irq = rq[7], spi_irq = rq[8];
  wire two_wire_irq = rq[9];
  prioritized_interrupt_controller u_dut (.ce(ce), .hsize(3'h2),
    .hready(hreadyout), .*);
  core_model u_core (.*);
  always #5 hclk = ~hclk;
  always @(posedge hclk) if (++cyc > 6000) begin
    fail_count++;
    test_done();
  end
  task automatic chk(input string n, input logic [31:0] e, s);
    cmp_count++;
    if (e !== s) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] v);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
    do @(posedge hclk); while (!hreadyout);
    {htrans, hwdata} <= {2'h0, v};
    do @(posedge hclk); while (!hreadyout);
    d = hrdata;
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [15:0] nx();
    sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
    return sd;
  endfunction
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 12'h000, 32'h0);
    chk("enable", 32'h0, d);
    bus(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h0, d);
    repeat (60) begin
      if (stk.size() > 0 && sd[3]) begin
        do_ret <= 1'b1;
        @(posedge hclk);
        do_ret <= 1'b0;
        void'(stk.pop_back());
      end
      en = nx() & 16'h83FF;
      bus(1'b1, 12'h000, en);
      pl = 10'(nx());
      bus(1'b1, 12'h004, pl);
      ph = 10'(nx());
      bus(1'b1, 12'h008, ph);
      rq <= 10'(nx());
      // Frozen: outputs hold and the bus stalls while requests move
      ce <= 1'b0;
      @(posedge hclk);
      ev = irq_vector;
      repeat (3) @(posedge hclk);
      chk("frozen", ev, irq_vector);
      chk("stall", 32'h0, hreadyout);
      ce <= 1'b1;
      repeat (5) @(posedge hclk);
      b = stk.size() ? stk[$] : -1;
      {ev, lv} = '0;
      pe = rq & en[9:0] & {10{en[15]}};
      iv = '0;
      foreach (stk[k]) iv[stk[k]] = 1'b1;
      // Strict compare keeps the earliest poll slot on a tie
      for (int i = 0; i < 10; i++) begin
        if (rq[i] && en[i] && en[15] &&
            int'({ph[i], pl[i]}) > b) begin
          b = {ph[i], pl[i]};
          lv = {ph[i], pl[i]};
          ev = 16'(8 * (i + 2 * (i == 7) + (i == 9)) + 3);
        end
      end
      bus(1'b0, 12'h010, 32'h0);
      chk("vector", {14'h0, lv, ev}, d);
      chk("level", lv, irq_level);
      chk("okay", 32'h1, {hresp, hreadyout});
      st = {7'h0, ev != 0, 4'h0, iv, 6'h0, pe};
      bus(1'b0, 12'h00C, 32'h0);
      chk("status", st, d);
      if (ev != 0) begin
        {wn, go} <= {sd[12:11], 1'b1};
        repeat (8) if (!irq_ack) @(posedge hclk);
        go <= 1'b0;
        @(posedge hclk);
        chk("taken", ev, got);
        stk.push_back(lv);
      end
    end
    test_done();
  end
endmodule // prioritized_interrupt_controller_tb
`default_nettype wire
